// *** rtl/bfd_defines.svh ***
`ifndef BFD_DEFINES_SVH
`define BFD_DEFINES_SVH

// ============================================================
// Register offsets
`define BFD_CFG_OFFS        8'h04
`define BFD_OFF_DELAY_OFFS  8'h06
`define BFD_DIM_CTRL_OFFS   8'h07
`define BFD_FADE_RATE_OFFS  8'h08
`define BFD_FULL_LVL_OFFS   8'h09
`define BFD_LEVEL_OFFS      8'h0A
`define BFD_STATE_OFFS      8'h0B

// ============================================================
// Field positions
`define BFD_DELAY_MSB       6
`define BFD_CODE_MSB        6
`define BFD_FADE_DOWN_MSB   7
`define BFD_FADE_DOWN_LSB   4
`define BFD_FADE_UP_MSB     3
`define BFD_FADE_UP_LSB     0
`define BFD_LAW_MSB         2
`define BFD_LAW_LSB         1
`define BFD_OVERRIDE_BIT    0

// ============================================================
// Reset values
`define BFD_REG_RESET       8'h00

// ============================================================
// Timing
`define BFD_CLK_PERIOD_NS   5
`define BFD_SEC_NS          1000000000
`define BFD_TENTH_NS        100000000
`define BFD_SEC_CYC         (`BFD_SEC_NS / `BFD_CLK_PERIOD_NS)
`define BFD_TENTH_CYC       (`BFD_TENTH_NS / `BFD_CLK_PERIOD_NS)
`define BFD_FULL_SCALE      127

`endif

// *** rtl/bfd_pkg.sv ***
package bfd_pkg;

   typedef enum logic [2:0]
   {
      BFD_ST_OFF  = 3'b000,
      BFD_ST_UP   = 3'b001,
      BFD_ST_FULL = 3'b010,
      BFD_ST_DIM  = 3'b011,
      BFD_ST_DOWN = 3'b100
   } bfd_state_e;

   typedef enum logic [1:0]
   {
      BFD_LAW_LINEAR  = 2'b00,
      BFD_LAW_SQUARE  = 2'b01,
      BFD_LAW_CUBIC10 = 2'b10,
      BFD_LAW_CUBIC11 = 2'b11
   } bfd_law_e;

   typedef logic [6:0] bfd_code_t;

   // Full-scale ramp time per rate code, in tenths of a second
   function automatic int unsigned bfd_rate_tenths(input int unsigned code);
      int unsigned t;
      t = 1;
      case (code)
         0:  t = 1;
         1:  t = 3;
         2:  t = 6;
         3:  t = 9;
         4:  t = 12;
         5:  t = 15;
         6:  t = 18;
         7:  t = 21;
         8:  t = 24;
         9:  t = 28;
         10: t = 31;
         11: t = 35;
         12: t = 40;
         13: t = 45;
         14: t = 50;
         15: t = 55;
         default: t = 1;
      endcase
      return t;
   endfunction

endpackage

// *** rtl/bfd_fade_ramp.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bfd_defines.svh"

module bfd_fade_ramp
   import bfd_pkg::*;
#(
   parameter int unsigned TENTH_CYC = `BFD_TENTH_CYC
)
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire bfd_code_t  target,
   input  wire logic [3:0] rate_up,
   input  wire logic [3:0] rate_down,
   output var  bfd_code_t  level,
   output logic            at_target
);

   // ============================================================
   // Step period per rate code
   logic [31:0] period_tab [16];

   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_tab
         localparam int unsigned CYC =
            bfd_rate_tenths(g) * TENTH_CYC / `BFD_FULL_SCALE;
         assign period_tab[g] = (CYC < 1) ? 32'h0000_0001 : 32'(CYC);
      end
   endgenerate

   // ============================================================
   // Stepper
   bfd_code_t   level_q, level_d;
   logic [31:0] cnt_q, cnt_d;
   logic [31:0] period;
   logic        going_up;

   assign going_up  = (level_q < target);
   assign at_target = (level_q == target);
   assign level     = level_q;

   always_comb
   begin
      // Rate is per step, so short ramps finish proportionally sooner
      period  = going_up ? period_tab[rate_up] : period_tab[rate_down];
      level_d = level_q;
      cnt_d   = cnt_q;
      if (at_target)
      begin
         cnt_d = 32'h0000_0000;
      end
      else if (cnt_q + 32'h0000_0001 >= period)
      begin
         cnt_d   = 32'h0000_0000;
         level_d = going_up ? level_q + 7'h01 : level_q - 7'h01;
      end
      else
      begin
         cnt_d = cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         level_q <= 7'h00;
         cnt_q   <= 32'h0000_0000;
      end
      else
      begin
         level_q <= level_d;
         cnt_q   <= cnt_d;
      end
   end

endmodule
`default_nettype wire

// *** rtl/bfd_backlight_ctrl.sv ***
// Function
// RL1 - Dim delay is seven bits; zero disables it, else whole seconds.
// RL2 - Dim delay counting begins only once level reaches full brightness.
// RL3 - Dim delay expiry moves the target from full to dim level.
// RL4 - Fade-down rate sits in bits 7:4; zero means near-instant change.
// RL5 - Nonzero fade-down ramps from present level to dim or off.
// RL6 - Fade-down code sets full 30 mA to zero time, 0.3 s steps; table runs 0.3 s to 5.5 s, steps of 0.3 s up to 2.4 s then uneven.
// RL7 - Fixed step rate; shorter level spans finish proportionally sooner.
// RL8 - Fade-up rate sits in bits 3:0; zero means near-instant change.
// RL9 - Nonzero fade-up ramps from present level to full on turn-on.
// RL10 - Fade-up code sets full ramp time, 0.3 s to 5.5 s.
// RL11 - Disabled fading still ramps quickly, about 100 ms, not one step.
// RL12 - Full brightness code is seven bits, mapped by chosen law.
// RL13 - Two-bit field selects linear, square or two cubic mappings.
// RL14 - Off delay starts after dim delay when enabled, then turns off.
// RL15 - One-second tick drives delays; count restarts on reaching full.
// RL16 - Reserved bit 7 of delay and level registers reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "bfd_defines.svh"

module bfd_backlight_ctrl
   import bfd_pkg::*;
#(
   parameter int unsigned SEC_CYC   = `BFD_SEC_CYC,
   parameter int unsigned TENTH_CYC = `BFD_TENTH_CYC
)
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       reg_wr_en,
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       backlight_on,
   input  wire bfd_code_t  dim_level_code,
   output bfd_code_t       sink_code,
   output bfd_law_e        sink_law
);

   // ============================================================
   // Registers
   logic [2:0] cfg_q, cfg_d;
   bfd_code_t  off_delay_q, off_delay_d;
   bfd_code_t  dim_delay_q, dim_delay_d;
   logic [7:0] fade_rate_q, fade_rate_d;
   bfd_code_t  full_code_q, full_code_d;
   logic [7:0] rdata_q, rdata_d;

   bfd_state_e state_q, state_d;
   bfd_code_t  level;
   logic       at_target;

   always_comb
   begin
      cfg_d       = cfg_q;
      off_delay_d = off_delay_q;
      dim_delay_d = dim_delay_q;
      fade_rate_d = fade_rate_q;
      full_code_d = full_code_q;
      rdata_d     = rdata_q;
      if (reg_wr_en)
      begin
         // RL16 reserved bit dropped
         case (reg_addr)
            `BFD_CFG_OFFS:       cfg_d       = reg_wdata[2:0];
            `BFD_OFF_DELAY_OFFS: off_delay_d = reg_wdata[`BFD_DELAY_MSB:0];
            // RL1 dim delay field
            `BFD_DIM_CTRL_OFFS:  dim_delay_d = reg_wdata[`BFD_DELAY_MSB:0];
            `BFD_FADE_RATE_OFFS: fade_rate_d = reg_wdata;
            // RL12 full code field
            `BFD_FULL_LVL_OFFS:  full_code_d = reg_wdata[`BFD_CODE_MSB:0];
            default:             cfg_d       = cfg_q;
         endcase
      end
      if (reg_rd_en)
      begin
         // RL16 reserved reads zero
         case (reg_addr)
            `BFD_CFG_OFFS:       rdata_d = {5'h00, cfg_q};
            `BFD_OFF_DELAY_OFFS: rdata_d = {1'b0, off_delay_q};
            `BFD_DIM_CTRL_OFFS:  rdata_d = {1'b0, dim_delay_q};
            `BFD_FADE_RATE_OFFS: rdata_d = fade_rate_q;
            `BFD_FULL_LVL_OFFS:  rdata_d = {1'b0, full_code_q};
            `BFD_LEVEL_OFFS:     rdata_d = {1'b0, level};
            `BFD_STATE_OFFS:     rdata_d = {5'h00, state_q};
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_q       <= 3'h0;
         off_delay_q <= 7'h00;
         dim_delay_q <= 7'h00;
         fade_rate_q <= `BFD_REG_RESET;
         full_code_q <= 7'h00;
         rdata_q     <= 8'h00;
      end
      else
      begin
         cfg_q       <= cfg_d;
         off_delay_q <= off_delay_d;
         dim_delay_q <= dim_delay_d;
         fade_rate_q <= fade_rate_d;
         full_code_q <= full_code_d;
         rdata_q     <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ============================================================
   // Rate selection
   logic [3:0] rate_up, rate_down;
   logic       fade_override;

   assign fade_override = cfg_q[`BFD_OVERRIDE_BIT];

   // Override forces the quick default ramp in both directions
   always_comb
   begin
      // RL8 fade-up nibble
      rate_up   = fade_override ? 4'h0
                : fade_rate_q[`BFD_FADE_UP_MSB:`BFD_FADE_UP_LSB];
      // RL4 fade-down nibble
      rate_down = fade_override ? 4'h0
                : fade_rate_q[`BFD_FADE_DOWN_MSB:`BFD_FADE_DOWN_LSB];
   end

   // ============================================================
   // Sequencer with second tick
   logic [31:0] tick_q, tick_d;
   bfd_code_t   secs_q, secs_d;
   logic        on_q, on_d;
   bfd_code_t   target;
   logic        sec_tick;
   logic        restart;

   assign sec_tick = (tick_q + 32'h0000_0001 >= SEC_CYC);

   always_comb
   begin
      state_d = state_q;
      on_d    = backlight_on;
      restart = 1'b0;
      if (!backlight_on)
      begin
         // Fade-down must still settle into OFF once the level hits zero
         if (state_q == BFD_ST_DOWN && at_target)
         begin
            state_d = BFD_ST_OFF;
         end
         else if (state_q != BFD_ST_OFF)
         begin
            state_d = BFD_ST_DOWN;
         end
      end
      else
      begin
         case (state_q)
            BFD_ST_OFF:
            begin
               // Turn-on is edge based so a timed-out light stays off
               if (!on_q)
               begin
                  state_d = BFD_ST_UP;
               end
            end
            BFD_ST_UP:
            begin
               // RL2 start at full
               if (at_target)
               begin
                  state_d = BFD_ST_FULL;
                  restart = 1'b1;
               end
            end
            BFD_ST_FULL:
            begin
               if (!at_target)
               begin
                  state_d = BFD_ST_UP;
               end
               // RL3 dim on expiry
               else if (dim_delay_q != 7'h00 && sec_tick
                        && secs_q + 7'h01 == dim_delay_q)
               begin
                  state_d = BFD_ST_DIM;
                  restart = 1'b1;
               end
               // RL14 off without dim
               else if (dim_delay_q == 7'h00 && off_delay_q != 7'h00
                        && sec_tick && secs_q + 7'h01 == off_delay_q)
               begin
                  state_d = BFD_ST_DOWN;
               end
            end
            BFD_ST_DIM:
            begin
               // RL14 off after dim
               if (off_delay_q != 7'h00 && sec_tick
                   && secs_q + 7'h01 == off_delay_q)
               begin
                  state_d = BFD_ST_DOWN;
               end
            end
            BFD_ST_DOWN:
            begin
               if (!on_q)
               begin
                  state_d = BFD_ST_UP;
               end
               else if (at_target)
               begin
                  state_d = BFD_ST_OFF;
               end
            end
            default: state_d = BFD_ST_OFF;
         endcase
      end
   end

   always_comb
   begin
      tick_d = sec_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
      secs_d = sec_tick ? secs_q + 7'h01 : secs_q;
      // RL15 restart count
      if (restart || (state_q != BFD_ST_FULL && state_q != BFD_ST_DIM))
      begin
         tick_d = 32'h0000_0000;
         secs_d = 7'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= BFD_ST_OFF;
         tick_q  <= 32'h0000_0000;
         secs_q  <= 7'h00;
         on_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         tick_q  <= tick_d;
         secs_q  <= secs_d;
         on_q    <= on_d;
      end
   end

   // ============================================================
   // Target and ramp
   always_comb
   begin
      case (state_q)
         // RL9 ramp to full
         BFD_ST_UP:   target = full_code_q;
         BFD_ST_FULL: target = full_code_q;
         // RL5 ramp to dim
         BFD_ST_DIM:  target = dim_level_code;
         default:     target = 7'h00;
      endcase
   end

   // RL6 RL7 RL10 RL11 per-step rate table
   bfd_fade_ramp #(
      .TENTH_CYC (TENTH_CYC)
   ) u_ramp (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .target    (target),
      .rate_up   (rate_up),
      .rate_down (rate_down),
      .level     (level),
      .at_target (at_target)
   );

   // RL13 law to sinks
   assign sink_law  = bfd_law_e'(cfg_q[`BFD_LAW_MSB:`BFD_LAW_LSB]);
   assign sink_code = level;

endmodule
`default_nettype wire

// *** verif/bfd_backlight_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module bfd_backlight_props
   import bfd_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       reg_wr_en,
   input wire logic       reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       backlight_on,
   input wire bfd_code_t  dim_level_code,
   input wire bfd_code_t  sink_code,
   input wire bfd_law_e   sink_law
);
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // ============================================================
   // Register port
   sequence wr_rd(logic [7:0] a);
      reg_wr_en && reg_addr == a ##1 reg_rd_en && !reg_wr_en && reg_addr == a;
   endsequence

   a_dim_readback: assert property (
      wr_rd(8'h07) |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
      else $error("dim delay readback wrong");
   a_full_readback: assert property (
      wr_rd(8'h09) |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
      else $error("full code readback wrong");
   a_fade_readback: assert property (
      wr_rd(8'h08) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("fade rate readback wrong");
   a_rsvd_dim_zero: assert property (
      reg_rd_en && reg_addr == 8'h07 |=> !reg_rdata[7])
      else $error("dim delay bit 7 set");
   a_rsvd_full_zero: assert property (
      reg_rd_en && reg_addr == 8'h09 |=> !reg_rdata[7])
      else $error("full code bit 7 set");
   a_unmapped_zero: assert property (
      reg_rd_en && reg_addr > 8'h0B |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved");
   a_law_follow: assert property (
      reg_wr_en && reg_addr == 8'h04 |=> sink_law == $past(reg_wdata[2:1]))
      else $error("law not taken");

   // ============================================================
   // Ramp
   // Even a disabled fade must ramp, never jump
   a_step_one: assert property (
      sink_code == $past(sink_code) || sink_code == $past(sink_code) + 7'h01
      || sink_code == $past(sink_code) - 7'h01)
      else $error("sink code jumped");
   a_off_no_rise: assert property (
      !backlight_on && $past(!backlight_on) |=> sink_code <= $past(sink_code))
      else $error("code rose while off");
endmodule

bind bfd_backlight_ctrl bfd_backlight_props u_props
(
   .ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .backlight_on(backlight_on),
   .dim_level_code(dim_level_code), .sink_code(sink_code),
   .sink_law(sink_law)
);

`default_nettype wire

// *** verif/bfd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module bfd_host_model
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   time t_rel;

   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      t_rel     = 0;
   end

   // ============================================================
   // Byte access, entered just after a clock edge
   // Back-to-back writes gap one edge so the strobe never toggles twice
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (t_rel == $time)
      begin
         @(posedge ref_clk);
         #1;
      end
      reg_addr  = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(posedge ref_clk);
      #1 reg_wr_en = 1'b0;
      reg_wdata = ~d;
      t_rel = $time;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(posedge ref_clk);
      #1 reg_rd_en = 1'b0;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// *** verif/bfd_backlight_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module bfd_backlight_ctrl_bench;
   import bfd_pkg::*;

   logic       ref_clk;
   logic       resetn;
   logic       backlight_on;
   logic       reg_wr_en;
   logic       reg_rd_en;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   bfd_code_t  dim_level_code;
   bfd_code_t  sink_code;
   bfd_law_e   sink_law;
   int         errors = 0;
   int         n_checks = 0;
   int         cyc = 0;
   int         n;

   // Short counts: one second is 50 cycles, ramp period equals tenths
   bfd_backlight_ctrl #(.SEC_CYC(50), .TENTH_CYC(127)) dut
   (
      .ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .backlight_on(backlight_on),
      .dim_level_code(dim_level_code), .sink_code(sink_code),
      .sink_law(sink_law)
   );

   bfd_host_model host
   (
      .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );

   // ============================================================
   // Helpers
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, exp);
      logic [7:0] d;
      host.rd(a, d);
      check(nm, d, exp);
   endtask

   task automatic wait_code(input bfd_code_t c, output int k);
      k = 0;
      while (sink_code !== c && k < 2000)
      begin
         @(posedge ref_clk);
         #1 k++;
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ============================================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] adr [5] = '{8'h07, 8'h09, 8'h08, 8'h06, 8'h04};
      logic [7:0] msk [5] = '{8'h7F, 8'h7F, 8'hFF, 8'h7F, 8'h07};
      for (int i = 0; i < 5; i++)
      begin
         rd_chk("reset", adr[i], 8'h00);
         host.wr(adr[i], 8'hFF);
         rd_chk("rsvd", adr[i], msk[i]);
         host.wr(adr[i], 8'h00);
      end
      rd_chk("unmapped", 8'h20, 8'h00);
   endtask

   task automatic t_ramps();
      host.wr(8'h09, 8'h03);
      backlight_on = 1'b1;
      wait_code(7'h03, n);
      check("fast up", n >= 3 && n <= 6, 1);
      // State moves one edge after the level arrives
      @(posedge ref_clk);
      #1;
      rd_chk("full", 8'h0B, 8'h02);
      host.wr(8'h07, 8'h01);
      host.wr(8'h08, 8'h11);
      host.wr(8'h09, 8'h0C);
      // Nine steps at three cycles each
      wait_code(7'h0C, n);
      check("slow up", n >= 26 && n <= 32, 1);
      // One second, then eight steps down at three cycles
      wait_code(7'h04, n);
      check("dim", n >= 72 && n <= 80, 1);
      rd_chk("dim st", 8'h0B, 8'h03);
      rd_chk("level", 8'h0A, 8'h04);
      backlight_on = 1'b0;
      wait_code(7'h00, n);
      check("fade down", n >= 11 && n <= 16, 1);
      @(posedge ref_clk);
      #1;
      rd_chk("off st", 8'h0B, 8'h00);
   endtask

   task automatic t_off_delay();
      host.wr(8'h06, 8'h01);
      // Override must force the quick ramp despite slow rate codes
      host.wr(8'h04, 8'h01);
      host.wr(8'h08, 8'hFF);
      host.wr(8'h09, 8'h05);
      backlight_on = 1'b1;
      wait_code(7'h05, n);
      wait_code(7'h04, n);
      check("dim wait", n >= 50 && n <= 56, 1);
      wait_code(7'h00, n);
      check("off wait", n >= 52 && n <= 58, 1);
      @(posedge ref_clk);
      #1;
      rd_chk("off st", 8'h0B, 8'h00);
   endtask

   task automatic t_law();
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'h04, 8'(i * 2));
         check("law", sink_law, i[1:0]);
      end
   endtask

   // ============================================================
   // Run
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         finish_test();
      end
   end

   initial
   begin
      resetn = 1'b0;
      backlight_on = 1'b0;
      dim_level_code = 7'h04;
      repeat (3) @(posedge ref_clk);
      #1 resetn = 1'b1;
      t_regs();
      t_ramps();
      t_off_delay();
      t_law();
      finish_test();
   end
endmodule

`default_nettype wire
